// ===== shared/rx_addr_pkg.sv
package rx_addr_pkg;

    // Register offsets on the serial command port
    localparam logic [4:0] OFS_PIPE0_ADDR = 5'h0a;
    localparam logic [4:0] OFS_PIPE1_ADDR = 5'h0b;
    localparam logic [4:0] OFS_LOW_P2 = 5'h0c;
    localparam logic [4:0] OFS_LOW_P3 = 5'h0d;
    localparam logic [4:0] OFS_LOW_P4 = 5'h0e;
    localparam logic [4:0] OFS_LOW_P5 = 5'h0f;
    localparam logic [4:0] OFS_SEND_ADDR = 5'h10;
    localparam logic [4:0] OFS_PAYLEN_P0 = 5'h11;
    localparam logic [4:0] OFS_PAYLEN_P1 = 5'h12;
    localparam logic [4:0] OFS_PAYLEN_P2 = 5'h13;
    localparam logic [4:0] OFS_PAYLEN_P3 = 5'h14;

    // Reset values
    localparam logic [39:0] RST_PIPE0_ADDR = 40'he7e7e7e7e7;
    localparam logic [39:0] RST_PIPE1_ADDR = 40'hc2c2c2c2c2;
    localparam logic [39:0] RST_SEND_ADDR = 40'he7e7e7e7e7;
    localparam logic [7:0] RST_LOW_P2 = 8'hc3;
    localparam logic [7:0] RST_LOW_P3 = 8'hc4;
    localparam logic [7:0] RST_LOW_P4 = 8'hc5;
    localparam logic [7:0] RST_LOW_P5 = 8'hc6;
    localparam logic [5:0] RST_PAYLEN = 6'h00;

    // Field layout
    localparam int PAYLEN_MSB = 5;
    localparam int UPPER_LSB = 8;
    localparam int UPPER_MSB = 39;

    // Command byte prefixes, bits 7:5
    localparam logic [2:0] CMD_READ_PREFIX = 3'h0;
    localparam logic [2:0] CMD_WRITE_PREFIX = 3'h1;

    // Address width codes and byte counts
    localparam logic [1:0] AW_CODE_3 = 2'h1;
    localparam logic [1:0] AW_CODE_4 = 2'h2;
    localparam logic [2:0] AW_BYTES_3 = 3'h3;
    localparam logic [2:0] AW_BYTES_4 = 3'h4;
    localparam logic [2:0] AW_BYTES_5 = 3'h5;

    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_CMD = 5'b00010,
        ST_READ = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_IGNORE = 5'b10000
    } port_state_t;

    typedef struct packed
    {
        logic csActive;
        logic csStart;
        logic sckRise;
        logic sckFall;
        logic mosi;
    } pin_events_t;

    typedef struct packed
    {
        logic [5:0][39:0] pipeAddr;
        logic [39:0] sendAddr;
        logic [3:0][5:0] payloadLen;
        logic [3:0] pipeUsed;
    } listen_config_t;

endpackage

// ===== src/rx_pipe_address_width_regs.sv
// Overview of operation
// - Pipe one has a 40-bit read/write listen address at offset 0x0b.
// - Address registers load least significant byte first, as many bytes as the address width gives.
// - Pipes two to five store one low byte and take bits 39:8 from the pipe-one address.
// - The low bytes of pipes two to five sit at 0x0c to 0x0f and reset to 0xc3, 0xc4, 0xc5, 0xc6.
// - A 40-bit read/write send address sits at 0x10, least significant byte first.
// - Each payload-length register holds the received length in bytes, 1 to 32, at bits 5:0.
// - A payload length of zero marks the pipe unused, and lengths reset to zero.
// - Payload lengths of pipes zero to three sit at offsets 0x11 to 0x14.
// - Pipe zero has a 40-bit read/write listen address at 0x0a, least significant byte first.
// - Registers are reached over the serial port, the status byte shifting out with the command.
`timescale 1ns/1ps
`default_nettype none

module rx_pipe_address_width_regs
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    input wire logic [7:0] statusByte,
    input wire logic [1:0] addressWidthSetting,
    output rx_addr_pkg::listen_config_t listenConfig
);

    rx_addr_pkg::pin_events_t pins;
    rx_addr_pkg::port_state_t state_q;
    logic [2:0] bitCnt_q;
    logic [7:0] rxShift_q;
    logic [7:0] txByte_q;
    logic [4:0] regAddr_q;
    logic [2:0] byteIdx_q;
    logic misoBit_q;
    logic [39:0] pipe0Addr_q;
    logic [39:0] pipe1Addr_q;
    logic [39:0] sendAddr_q;
    logic [3:0][7:0] lowByte_q;
    logic [3:0][5:0] payLen_q;
    logic [7:0] rxByte;
    logic byteDone;
    logic [2:0] awBytes;

    spi_pin_sync pinSync
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .sck(sck),
        .csN(csN),
        .mosi(mosi),
        .pins(pins)
    );

    // Number of address bytes the host sends for the configured width
    function automatic logic [2:0] widthBytes(input logic [1:0] code);
        logic [2:0] n;
        unique case (code)
            rx_addr_pkg::AW_CODE_3: n = rx_addr_pkg::AW_BYTES_3;
            rx_addr_pkg::AW_CODE_4: n = rx_addr_pkg::AW_BYTES_4;
            default: n = rx_addr_pkg::AW_BYTES_5;
        endcase
        return n;
    endfunction

    // Byte of a 40-bit register, lowest first
    function automatic logic [7:0] pickByte(input logic [39:0] word,
                                            input logic [2:0] idx);
        return (idx < rx_addr_pkg::AW_BYTES_5) ? word[idx * 8 +: 8] : 8'h00;
    endfunction

    // Replace one byte of a 40-bit register
    function automatic logic [39:0] putByte(input logic [39:0] word,
                                            input logic [2:0] idx,
                                            input logic [7:0] b);
        logic [39:0] w;
        w = word;
        if (idx < rx_addr_pkg::AW_BYTES_5)
        begin
            w[idx * 8 +: 8] = b;
        end
        return w;
    endfunction

    // Read data for a register and byte index; unmapped reads as zero
    function automatic logic [7:0] readByte(input logic [4:0] addr,
                                            input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (addr)
            rx_addr_pkg::OFS_PIPE0_ADDR: b = pickByte(pipe0Addr_q, idx);
            rx_addr_pkg::OFS_PIPE1_ADDR: b = pickByte(pipe1Addr_q, idx);
            rx_addr_pkg::OFS_SEND_ADDR: b = pickByte(sendAddr_q, idx);
            rx_addr_pkg::OFS_LOW_P2, rx_addr_pkg::OFS_LOW_P3,
            rx_addr_pkg::OFS_LOW_P4, rx_addr_pkg::OFS_LOW_P5:
                if (idx == 3'h0)
                    b = lowByte_q[addr[1:0]];
            rx_addr_pkg::OFS_PAYLEN_P0, rx_addr_pkg::OFS_PAYLEN_P1,
            rx_addr_pkg::OFS_PAYLEN_P2, rx_addr_pkg::OFS_PAYLEN_P3:
                if (idx == 3'h0)
                    b = {2'b00, payLen_q[addr[1:0] - 2'h1]};
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    assign rxByte = {rxShift_q[6:0], pins.mosi};
    assign byteDone = pins.sckRise && bitCnt_q == rx_addr_pkg::LAST_BIT;
    assign awBytes = widthBytes(addressWidthSetting);

    // Command sequencing over the serial port
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= rx_addr_pkg::ST_IDLE;
            regAddr_q <= 5'h00;
            byteIdx_q <= 3'h0;
        end
        else if (!pins.csActive)
        begin
            state_q <= rx_addr_pkg::ST_IDLE;
        end
        else if (pins.csStart)
        begin
            state_q <= rx_addr_pkg::ST_CMD;
            byteIdx_q <= 3'h0;
        end
        else if (byteDone)
        begin
            unique case (state_q)
                rx_addr_pkg::ST_CMD:
                begin
                    regAddr_q <= rxByte[4:0];
                    if (rxByte[7:5] == rx_addr_pkg::CMD_READ_PREFIX)
                    begin
                        state_q <= rx_addr_pkg::ST_READ;
                    end
                    else if (rxByte[7:5] == rx_addr_pkg::CMD_WRITE_PREFIX)
                    begin
                        state_q <= rx_addr_pkg::ST_WRITE;
                    end
                    else
                    begin
                        state_q <= rx_addr_pkg::ST_IGNORE;
                    end
                end
                rx_addr_pkg::ST_READ, rx_addr_pkg::ST_WRITE:
                begin
                    if (byteIdx_q != 3'h7)
                    begin
                        byteIdx_q <= byteIdx_q + 3'h1;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // Bit counter and input shifter
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bitCnt_q <= 3'h0;
            rxShift_q <= 8'h00;
        end
        else if (!pins.csActive || pins.csStart)
        begin
            bitCnt_q <= 3'h0;
        end
        else if (pins.sckRise)
        begin
            bitCnt_q <= bitCnt_q + 3'h1;
            rxShift_q <= rxByte;
        end
    end

    // Output byte: status during the command, register data after it
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            txByte_q <= 8'h00;
            misoBit_q <= 1'b0;
        end
        else if (pins.csStart)
        begin
            txByte_q <= statusByte;
            misoBit_q <= statusByte[7];
        end
        else if (byteDone)
        begin
            if (state_q == rx_addr_pkg::ST_CMD)
            begin
                txByte_q <= readByte(rxByte[4:0], 3'h0);
            end
            else if (state_q == rx_addr_pkg::ST_READ)
            begin
                txByte_q <= readByte(regAddr_q, byteIdx_q + 3'h1);
            end
            else
            begin
                txByte_q <= 8'h00;
            end
        end
        else if (pins.sckFall && pins.csActive)
        begin
            misoBit_q <= txByte_q[rx_addr_pkg::LAST_BIT - bitCnt_q];
        end
    end

    // Address registers, written byte by byte as each byte completes
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pipe0Addr_q <= rx_addr_pkg::RST_PIPE0_ADDR;
            pipe1Addr_q <= rx_addr_pkg::RST_PIPE1_ADDR;
            sendAddr_q <= rx_addr_pkg::RST_SEND_ADDR;
            lowByte_q[0] <= rx_addr_pkg::RST_LOW_P2;
            lowByte_q[1] <= rx_addr_pkg::RST_LOW_P3;
            lowByte_q[2] <= rx_addr_pkg::RST_LOW_P4;
            lowByte_q[3] <= rx_addr_pkg::RST_LOW_P5;
        end
        else if (byteDone && state_q == rx_addr_pkg::ST_WRITE)
        begin
            if (byteIdx_q < awBytes)
            begin
                if (regAddr_q == rx_addr_pkg::OFS_PIPE0_ADDR)
                begin
                    pipe0Addr_q <= putByte(pipe0Addr_q, byteIdx_q, rxByte);
                end
                if (regAddr_q == rx_addr_pkg::OFS_PIPE1_ADDR)
                begin
                    pipe1Addr_q <= putByte(pipe1Addr_q, byteIdx_q, rxByte);
                end
                if (regAddr_q == rx_addr_pkg::OFS_SEND_ADDR)
                begin
                    sendAddr_q <= putByte(sendAddr_q, byteIdx_q, rxByte);
                end
            end
            if (byteIdx_q == 3'h0 && regAddr_q >= rx_addr_pkg::OFS_LOW_P2
                && regAddr_q <= rx_addr_pkg::OFS_LOW_P5)
            begin
                lowByte_q[regAddr_q[1:0]] <= rxByte;
            end
        end
    end

    // Payload lengths, reserved bits dropped
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            payLen_q <= {4{rx_addr_pkg::RST_PAYLEN}};
        end
        else if (byteDone && state_q == rx_addr_pkg::ST_WRITE
                 && byteIdx_q == 3'h0
                 && regAddr_q >= rx_addr_pkg::OFS_PAYLEN_P0
                 && regAddr_q <= rx_addr_pkg::OFS_PAYLEN_P3)
        begin
            payLen_q[regAddr_q[1:0] - 2'h1] <=
                rxByte[rx_addr_pkg::PAYLEN_MSB:0];
        end
    end

    assign miso = misoBit_q;
    assign misoOe = pins.csActive;

    // Full listen addresses seen by the radio
    always_comb
    begin
        listenConfig.pipeAddr[0] = pipe0Addr_q;
        listenConfig.pipeAddr[1] = pipe1Addr_q;
        for (int p = 0; p < 4; p++)
        begin
            listenConfig.pipeAddr[p + 2] =
                {pipe1Addr_q[rx_addr_pkg::UPPER_MSB:rx_addr_pkg::UPPER_LSB],
                 lowByte_q[p]};
        end
        listenConfig.sendAddr = sendAddr_q;
        listenConfig.payloadLen = payLen_q;
        for (int p = 0; p < 4; p++)
        begin
            listenConfig.pipeUsed[p] = payLen_q[p] != 6'h00;
        end
    end

endmodule

`default_nettype wire

// ===== src/spi_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module spi_pin_sync
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    output rx_addr_pkg::pin_events_t pins
);

    logic [2:0] stage1_q;
    logic [2:0] stage2_q;
    logic sckPrev_q;
    logic csPrev_q;

    // Two flip-flops per pin; idle levels are select high, clock low
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1_q <= 3'h2;
            stage2_q <= 3'h2;
        end
        else
        begin
            stage1_q <= {mosi, csN, sck};
            stage2_q <= stage1_q;
        end
    end

    // Edge history from the second stage only
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sckPrev_q <= 1'b0;
            csPrev_q <= 1'b0;
        end
        else
        begin
            sckPrev_q <= stage2_q[0];
            csPrev_q <= ~stage2_q[1];
        end
    end

    assign pins.csActive = ~stage2_q[1];
    assign pins.csStart = ~stage2_q[1] & ~csPrev_q;
    assign pins.sckRise = stage2_q[0] & ~sckPrev_q;
    assign pins.sckFall = ~stage2_q[0] & sckPrev_q;
    assign pins.mosi = stage2_q[2];

endmodule

`default_nettype wire

// ===== verification/rx_pipe_address_width_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rx_pipe_address_width_regs_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b0;
    logic [39:0] mirror = 40'h0000000000;
    bit useMirror = 1'b0;
    logic [7:0] statusByte = 8'h00;
    logic [1:0] addressWidthSetting = 2'h3;
    wire logic sck, csN, mosi, miso, misoOe, done;
    wire logic [7:0] rxByte;
    rx_addr_pkg::listen_config_t cfg;
    logic [7:0] img [0:31][0:4];
    logic [8:0] expQ [$];
    int err_count = 0;
    int checks = 0;
    int seed = 32'haf9b;

    always #50 clock = ~clock;

    spi_host_model host
    (
        .clock(clock), .miso(miso), .sck(sck), .csN(csN), .mosi(mosi),
        .done(done), .rxByte(rxByte)
    );
    rx_pipe_address_width_regs dut
    (
        .clock(clock), .sys_rst(sys_rst), .sck(sck), .csN(csN),
        .mosi(mosi), .miso(miso), .misoOe(misoOe), .statusByte(statusByte),
        .addressWidthSetting(addressWidthSetting), .listenConfig(cfg)
    );

    task automatic stop_test();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpCfg(input rx_addr_pkg::listen_config_t got,
                          input rx_addr_pkg::listen_config_t exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic rx_addr_pkg::listen_config_t expCfg();
        rx_addr_pkg::listen_config_t c;
        for (int p = 0; p < 6; p++)
            for (int b = 0; b < 5; b++)
                c.pipeAddr[p][8*b +: 8] = (p < 2 || b == 0) ?
                    img[10 + p][b] : img[11][b];
        for (int b = 0; b < 5; b++)
            c.sendAddr[8*b +: 8] = img[16][b];
        for (int p = 0; p < 4; p++)
        begin
            c.payloadLen[p] = img[17 + p][0][5:0];
            c.pipeUsed[p] = img[17 + p][0] != 8'h00;
        end
        return c;
    endfunction

    // One framed access: command byte then n data bytes
    task automatic access(input logic [7:0] cmd, input int n);
        logic [7:0] d;
        logic [4:0] a;
        int w;
        int len;
        a = cmd[4:0];
        d = 8'($random(seed));
        @(posedge clock);
        statusByte <= d;
        len = (a == 5'h0a || a == 5'h0b || a == 5'h10) ? 5 : 1;
        w = (len == 1) ? 1 : (addressWidthSetting == 2'h1) ? 3 :
            (addressWidthSetting == 2'h2) ? 4 : 5;
        expQ.push_back({1'b1, d});
        host.open_frame();
        host.xfer(cmd);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            if (a >= 5'h11)
                d = d % 8'd33;
            if (useMirror)
                d = mirror[8*i +: 8];
            if (cmd[5])
            begin
                expQ.push_back(9'h000);
                if (i < w && cmd[7:6] == 2'b00 && a >= 5'h0a && a <= 5'h14)
                    img[a][i] = d;
                host.xfer(d);
            end
            else
            begin
                expQ.push_back({1'b1, (i < len) ? img[a][i] : 8'h00});
                host.xfer(8'hff);
            end
        end
        host.close_frame();
    endtask

    always @(posedge clock)
        if (done === 1'b1 && expQ.size() > 0)
        begin
            if (expQ[0][8])
                cmpByte(rxByte, expQ[0][7:0]);
            void'(expQ.pop_front());
        end

    initial
    begin
        sys_rst <= 1'b1;
        foreach (img[a, b])
            img[a][b] = 8'h00;
        for (int b = 0; b < 5; b++)
        begin
            img[10][b] = 8'he7;
            img[11][b] = 8'hc2;
            img[16][b] = 8'he7;
        end
        for (int p = 0; p < 4; p++)
            img[12 + p][0] = 8'(8'hc3 + p);
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        cmpCfg(cfg, expCfg());
        for (int a = 10; a <= 21; a++)
            access(8'(a), 5);
        for (int w = 1; w <= 3; w++)
        begin
            addressWidthSetting <= 2'(w);
            access(8'h2b, w + 2);
            access(8'h0b, 5);
            access(8'h2a, w + 2);
            access(8'h30, w + 2);
            cmpCfg(cfg, expCfg());
        end
        mirror = {8'($random(seed)), 32'($random(seed))};
        useMirror = 1'b1;
        access(8'h2a, 5);
        access(8'h30, 5);
        useMirror = 1'b0;
        cmpCfg(cfg, expCfg());
        for (int a = 'h2c; a <= 'h34; a++)
            access(8'(a), 1);
        access(8'hab, 3);
        access(8'h35, 1);
        for (int a = 10; a <= 21; a++)
            access(8'(a), 5);
        cmpCfg(cfg, expCfg());
        cmpByte(8'(expQ.size()), 8'h00);
        repeat (4) @(posedge clock);
        stop_test();
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        err_count++;
        stop_test();
    end
endmodule

`default_nettype wire

// ===== verification/rx_pipe_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module rx_pipe_regs_props
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    input wire logic miso,
    input wire logic misoOe,
    input wire logic [7:0] statusByte,
    input wire logic [1:0] addressWidthSetting,
    input wire rx_addr_pkg::listen_config_t listenConfig
);
    rx_addr_pkg::listen_config_t c;
    assign c = listenConfig;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_rstAddr;
        disable iff (1'b0) sys_rst |-> c.pipeAddr[0] == 40'he7e7e7e7e7
            && c.pipeAddr[1] == 40'hc2c2c2c2c2 && c.sendAddr == 40'he7e7e7e7e7;
    endproperty
    a_rstAddr: assert property (p_rstAddr)
        else $error("address reset value wrong");
    property p_rstLow;
        disable iff (1'b0) sys_rst |-> c.pipeAddr[2][7:0] == 8'hc3
            && c.pipeAddr[3][7:0] == 8'hc4 && c.pipeAddr[4][7:0] == 8'hc5
            && c.pipeAddr[5][7:0] == 8'hc6;
    endproperty
    a_rstLow: assert property (p_rstLow)
        else $error("low byte reset value wrong");
    property p_rstLen;
        disable iff (1'b0) sys_rst |-> c.payloadLen == 24'h000000;
    endproperty
    a_rstLen: assert property (p_rstLen)
        else $error("length reset value wrong");
    property p_upper;
        c.pipeAddr[2][39:8] == c.pipeAddr[1][39:8]
            && c.pipeAddr[3][39:8] == c.pipeAddr[1][39:8]
            && c.pipeAddr[4][39:8] == c.pipeAddr[1][39:8]
            && c.pipeAddr[5][39:8] == c.pipeAddr[1][39:8];
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper bytes differ from pipe one");
    property p_used;
        c.pipeUsed == {|c.payloadLen[3], |c.payloadLen[2],
            |c.payloadLen[1], |c.payloadLen[0]};
    endproperty
    a_used: assert property (p_used)
        else $error("pipe used flag wrong");
    property p_oeOn;
        (!csN) [*4] |-> misoOe;
    endproperty
    a_oeOn: assert property (p_oeOn)
        else $error("miso not driven in frame");
    property p_oeOff;
        csN [*4] |-> !misoOe;
    endproperty
    a_oeOff: assert property (p_oeOff)
        else $error("miso driven outside frame");
    property p_misoHold;
        sck [*4] |-> $stable(miso);
    endproperty
    a_misoHold: assert property (p_misoHold)
        else $error("miso moved while clock high");
    property p_cfgStable;
        csN [*4] |-> $stable(c);
    endproperty
    a_cfgStable: assert property (p_cfgStable)
        else $error("config changed outside frame");
    property p_cfgChange;
        !$stable(c) |-> !csN && !$past(csN, 4);
    endproperty
    a_cfgChange: assert property (p_cfgChange)
        else $error("config changed early in frame");
endmodule

bind rx_pipe_address_width_regs rx_pipe_regs_props u_props
(
    .clock(clock), .sys_rst(sys_rst), .sck(sck), .csN(csN), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .statusByte(statusByte),
    .addressWidthSetting(addressWidthSetting), .listenConfig(listenConfig)
);

`default_nettype wire

// ===== verification/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host_model
(
    input wire logic clock,
    input wire logic miso,
    output var logic sck,
    output var logic csN,
    output var logic mosi,
    output var logic done,
    output var logic [7:0] rxByte
);
    initial
    begin
        sck = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
        done = 1'b0;
        rxByte = 8'h00;
    end

    task automatic open_frame();
        @(posedge clock);
        csN <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // Mode 0 byte, MSB first, 800 ns serial period; miso taken at each rise
    task automatic xfer(input logic [7:0] tx);
        logic [7:0] r;
        @(posedge clock);
        done <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            mosi <= tx[i];
            repeat (4) @(posedge clock);
            sck <= 1'b1;
            r[i] = miso;
            repeat (4) @(posedge clock);
            sck <= 1'b0;
        end
        rxByte <= r;
        done <= 1'b1;
    endtask

    // Released data line shows the inverse of its last value
    task automatic close_frame();
        @(posedge clock);
        done <= 1'b0;
        repeat (3) @(posedge clock);
        csN <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clock);
    endtask
endmodule

`default_nettype wire
